// ---- fpep_prot.sv ----
// Flash program/erase protection: control registers, protection gating and NMI mask.
// Assumes standby, watchdog and runaway inputs come from logic on CLK; pins are synchronised.
//
// Notes on behaviour
// - Write-enable pin low clears registers, blocks all.
// - Any reset or standby initialises registers.
// - Error sets flag, keeps settings, aborts operation.
// - Runaway during write or erase, or algorithm breach, raises the error.
// - With error, bits writable but no transition.
// - With error, verify modes still reachable.
// - Only resets or hardware standby clear error.
// - Software standby with error initialises registers.
// - Write-enable pin low cancels RAM overlay.
// - Hardware protection makes all blocks unerasable.
// - Overlay select blocks program/erase, allows verify.
// - Software protection prevents program/erase transitions.
// - Block select guards erase; zero guards all.
// - NMI masked while write or erase set.
// - Boot mode masks NMI until RAM branch.
// - After branch, NMI allowed unless program/erase.
// - NMI masked under error.
// - Flash reads undefined during program/erase.
// - Only defined conditions set the error.
// - Modes entered only through control bits.
// - Gate bit zero forbids program and erase.
`timescale 1ns/1ns
`default_nettype none

module fpep_prot (
    input  wire logic                   CLK,
    input  wire logic                   SYS_RST,
    input  wire logic                   PSEL,
    input  wire logic                   PENABLE,
    input  wire logic                   PWRITE,
    input  wire logic [7:0]             PADDR,
    input  wire logic [31:0]            PWDATA,
    output var  logic [31:0]            PRDATA,
    output var  logic                   PREADY,
    output var  logic                   PSLVERR,
    input  wire logic                   FLASH_WRITE_ENABLE_PIN,
    input  wire logic                   BOOT_MODE_PIN,
    input  wire logic                   WATCHDOG_UNIT_RST,
    input  wire logic                   HW_STANDBY,
    input  wire logic                   SW_STANDBY,
    input  wire logic                   CPU_RUNAWAY,
    input  wire logic                   FETCH_VALID,
    input  wire logic [19:0]            FETCH_ADDR,
    output var  fpep_pkg::fpep_out_t    MODE_FLAGS,
    output var  logic [7:0]             ERASE_BLOCK_EN,
    output var  logic [2:0]             OVERLAY_AREA,
    output var  logic                   OVERLAY_EN,
    output var  logic                   NMI_MASK
);

    logic [1:0]                  fwe_sync_q;
    logic [1:0]                  boot_sync_q;
    logic [fpep_pkg::CTRL_W-1:0] ctrl_q;
    logic [fpep_pkg::CTRL_W-1:0] ctrl_d;
    logic [fpep_pkg::EBLK_W-1:0] eblk_q;
    logic [fpep_pkg::EBLK_W-1:0] eblk_d;
    logic [fpep_pkg::RAMCTL_W-1:0] ramctl_q;
    logic [fpep_pkg::RAMCTL_W-1:0] ramctl_d;
    logic                        err_q;
    logic                        err_d;
    logic                        boot_q;
    logic                        boot_d;
    logic                        boot_arm_q;
    fpep_pkg::fpep_mode_t        mode_q;
    fpep_pkg::fpep_mode_t        mode_d;
    fpep_pkg::fpep_out_t         out_d;
    logic                        fwe_s;
    logic                        err_clear;
    logic                        reg_init;
    logic                        wr_take;
    logic                        rd_take;
    logic                        breach;
    logic                        err_set;
    logic                        mapped;
    logic [31:0]                 rd_word;

    assign fwe_s = fwe_sync_q[1];

    // Two flip-flops on each pin; only the second stage feeds logic.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            fwe_sync_q <= 2'h0;
        end else begin
            fwe_sync_q <= {fwe_sync_q[0], FLASH_WRITE_ENABLE_PIN};
        end
    end

    // The strap keeps sampling through reset, so it has settled when it is caught.
    always_ff @(posedge CLK) begin
        boot_sync_q <= {boot_sync_q[0], BOOT_MODE_PIN};
    end

    // A read is answered after one wait state; a write lands on the pready edge.
    assign wr_take = PSEL & PENABLE & PREADY & PWRITE;
    assign rd_take = PSEL & PENABLE & ~PREADY & ~PWRITE;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == fpep_pkg::OFF_CTRL) || (a == fpep_pkg::OFF_EBLK) ||
                    (a == fpep_pkg::OFF_STAT) || (a == fpep_pkg::OFF_RAMCTL);
    endfunction

    assign mapped = is_mapped(PADDR);

    assign err_clear = WATCHDOG_UNIT_RST | HW_STANDBY;
    // Standby of either kind, the watchdog and the pin all reinitialise the registers.
    assign reg_init  = err_clear | SW_STANDBY | ~fwe_s;

    // A control write that skips the setup stage or mixes program with erase breaks the
    // algorithm; it only counts while the gate is open and the pin is high.
    assign breach = wr_take && (PADDR == fpep_pkg::OFF_CTRL) && fwe_s &&
                    ctrl_q[fpep_pkg::B_SWGATE] &&
                    ((PWDATA[fpep_pkg::B_WRITE] && !PWDATA[fpep_pkg::B_WSETUP]) ||
                     (PWDATA[fpep_pkg::B_ERASE] && !PWDATA[fpep_pkg::B_ESETUP]) ||
                     (PWDATA[fpep_pkg::B_WRITE] && PWDATA[fpep_pkg::B_ERASE]));

    // Only runaway during an operation and algorithm breaches set the flag.
    assign err_set = breach || (CPU_RUNAWAY && (ctrl_q[fpep_pkg::B_WRITE] ||
                     ctrl_q[fpep_pkg::B_ERASE]));

    always_comb begin
        ctrl_d   = ctrl_q;
        eblk_d   = eblk_q;
        ramctl_d = ramctl_q;
        if (reg_init) begin
            ctrl_d = fpep_pkg::CTRL_RST;
            eblk_d = fpep_pkg::EBLK_RST;
        end else if (wr_take) begin
            // Writes are accepted under error; the mode decode refuses program and erase.
            if (PADDR == fpep_pkg::OFF_CTRL) begin
                ctrl_d = PWDATA[fpep_pkg::CTRL_W-1:0];
            end
            if (PADDR == fpep_pkg::OFF_EBLK) begin
                eblk_d = PWDATA[fpep_pkg::EBLK_W-1:0];
            end
        end
        if (!fwe_s || SW_STANDBY || err_clear) begin
            ramctl_d = fpep_pkg::RAMCTL_RST;
        end else if (wr_take && PADDR == fpep_pkg::OFF_RAMCTL) begin
            ramctl_d = PWDATA[fpep_pkg::RAMCTL_W-1:0];
        end
    end

    // The setting bits are kept on an error; only the transition is cut.
    assign err_d = err_clear ? 1'b0 : (err_q | err_set);

    // Boot phase ends on the first fetch inside the RAM boot area.
    always_comb begin
        boot_d = boot_q;
        if (boot_arm_q) begin
            boot_d = boot_sync_q[1];
        end else if (FETCH_VALID && FETCH_ADDR >= fpep_pkg::BOOT_RAM_LO &&
                     FETCH_ADDR <= fpep_pkg::BOOT_RAM_HI) begin
            boot_d = 1'b0;
        end
    end

    // Modes follow only the control bits; program and erase are gated by pin, gate, error and overlay, verify and setup by pin and gate only.
    function automatic fpep_pkg::fpep_mode_t decode_mode(
        input logic [fpep_pkg::CTRL_W-1:0] c,
        input logic                        pin,
        input logic                        err,
        input logic                        ovl,
        input logic                        blk_any
    );
        logic gate;
        logic pe_ok;
        gate  = pin & c[fpep_pkg::B_SWGATE];
        pe_ok = gate & ~err & ~ovl;
        decode_mode = fpep_pkg::MODE_IDLE;
        if (c[fpep_pkg::B_WSETUP] && c[fpep_pkg::B_WRITE] && pe_ok) begin
            decode_mode = fpep_pkg::MODE_WRITE;
        end else if (c[fpep_pkg::B_ESETUP] && c[fpep_pkg::B_ERASE] && pe_ok && blk_any) begin
            decode_mode = fpep_pkg::MODE_ERASE;
        end else if (c[fpep_pkg::B_WSETUP] && gate) begin
            decode_mode = fpep_pkg::MODE_WSETUP;
        end else if (c[fpep_pkg::B_ESETUP] && gate) begin
            decode_mode = fpep_pkg::MODE_ESETUP;
        end else if (c[fpep_pkg::B_WCHECK] && gate) begin
            decode_mode = fpep_pkg::MODE_WCHECK;
        end else if (c[fpep_pkg::B_ECHECK] && gate) begin
            decode_mode = fpep_pkg::MODE_ECHECK;
        end
    endfunction

    assign mode_d = decode_mode(ctrl_d, fwe_s, err_d, ramctl_d[fpep_pkg::R_SELECT],
                                |eblk_d);

    always_comb begin
        out_d = '0;
        case (mode_d)
            fpep_pkg::MODE_WRITE: begin
                out_d.write_act = 1'b1;
                out_d.rd_undef  = 1'b1;
            end
            fpep_pkg::MODE_ERASE: begin
                out_d.erase_act = 1'b1;
                out_d.rd_undef  = 1'b1;
            end
            fpep_pkg::MODE_WCHECK: begin
                out_d.wcheck_act = 1'b1;
            end
            fpep_pkg::MODE_ECHECK: begin
                out_d.echeck_act = 1'b1;
            end
            default: begin
                out_d = '0;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ctrl_q   <= fpep_pkg::CTRL_RST;
            eblk_q   <= fpep_pkg::EBLK_RST;
            ramctl_q <= fpep_pkg::RAMCTL_RST;
        end else begin
            ctrl_q   <= ctrl_d;
            eblk_q   <= eblk_d;
            ramctl_q <= ramctl_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            err_q <= 1'b0;
        end else begin
            err_q <= err_d;
        end
    end

    // The strap is caught one cycle after release, never during reset.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            boot_arm_q <= 1'b1;
            boot_q     <= 1'b1;
        end else begin
            boot_arm_q <= 1'b0;
            boot_q     <= boot_d;
        end
    end

    // Outputs register the next-state values so the mask moves with the bits.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            mode_q         <= fpep_pkg::MODE_IDLE;
            MODE_FLAGS     <= '0;
            ERASE_BLOCK_EN <= 8'h00;
            OVERLAY_EN     <= 1'b0;
            OVERLAY_AREA   <= 3'h0;
            NMI_MASK       <= 1'b1;
        end else begin
            mode_q         <= mode_d;
            MODE_FLAGS     <= out_d;
            ERASE_BLOCK_EN <= out_d.erase_act ? eblk_d : 8'h00;
            OVERLAY_EN     <= ramctl_d[fpep_pkg::R_SELECT];
            OVERLAY_AREA   <= ramctl_d[2:0];
            NMI_MASK       <= ctrl_d[fpep_pkg::B_WRITE] | ctrl_d[fpep_pkg::B_ERASE] |
                              boot_d | err_d;
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (PADDR)
            fpep_pkg::OFF_CTRL: begin
                rd_word[fpep_pkg::CTRL_W-1:0] = ctrl_q;
            end
            fpep_pkg::OFF_EBLK: begin
                rd_word[fpep_pkg::EBLK_W-1:0] = eblk_q;
            end
            fpep_pkg::OFF_STAT: begin
                rd_word[fpep_pkg::S_MODE_LO +: 3] = mode_q;
                rd_word[fpep_pkg::S_NMI]          = NMI_MASK;
                rd_word[fpep_pkg::S_FWE]          = fwe_s;
                rd_word[fpep_pkg::S_BOOT]         = boot_q;
                rd_word[fpep_pkg::S_ERR]          = err_q;
            end
            fpep_pkg::OFF_RAMCTL: begin
                rd_word[fpep_pkg::RAMCTL_W-1:0] = ramctl_q;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= PSEL & PENABLE & ~PREADY;
            PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
            if (rd_take) begin
                PRDATA <= rd_word;
            end
        end
    end

    a_pin_low_init: assert property (@(posedge CLK) disable iff (SYS_RST)
        !fwe_s |=> (ctrl_q == 7'h00) && (eblk_q == 8'h00) && !OVERLAY_EN)
        else $error("pin low did not clear registers");

    a_wdt_init: assert property (@(posedge CLK) disable iff (SYS_RST)
        WATCHDOG_UNIT_RST |=> (ctrl_q == 7'h00) && !err_q && (MODE_FLAGS == '0))
        else $error("watchdog reset did not initialise");

    a_err_sticky: assert property (@(posedge CLK) disable iff (SYS_RST)
        err_q && !WATCHDOG_UNIT_RST && !HW_STANDBY |=> err_q)
        else $error("error flag cleared without reset");

    a_err_set_run: assert property (@(posedge CLK) disable iff (SYS_RST)
        CPU_RUNAWAY && ctrl_q[0] && !err_clear |=> err_q ##1 NMI_MASK || err_clear)
        else $error("runaway did not raise error");

    a_err_blocks: assert property (@(posedge CLK) disable iff (SYS_RST)
        err_q |-> !MODE_FLAGS.write_act && !MODE_FLAGS.erase_act && NMI_MASK)
        else $error("transition under error");

    a_err_verify: assert property (@(posedge CLK) disable iff (SYS_RST)
        $past(ctrl_d[2] && !ctrl_d[4] && ctrl_d[6] && fwe_s) |-> MODE_FLAGS.wcheck_act)
        else $error("verify refused");

    a_ovl_blocks: assert property (@(posedge CLK) disable iff (SYS_RST)
        OVERLAY_EN |-> !MODE_FLAGS.write_act && !MODE_FLAGS.erase_act)
        else $error("program under overlay");

    a_blk_zero: assert property (@(posedge CLK) disable iff (SYS_RST)
        (eblk_q == 8'h00) |-> !MODE_FLAGS.erase_act && (ERASE_BLOCK_EN == 8'h00))
        else $error("erase with no block");

    a_gate_off: assert property (@(posedge CLK) disable iff (SYS_RST)
        !ctrl_q[6] |-> (MODE_FLAGS == '0))
        else $error("operation with gate closed");

    a_nmi_pe: assert property (@(posedge CLK) disable iff (SYS_RST)
        (ctrl_q[0] || ctrl_q[1] || boot_q) |-> NMI_MASK)
        else $error("nmi open during operation");

    a_nmi_free: assert property (@(posedge CLK) disable iff (SYS_RST)
        !boot_q && !err_q && !ctrl_q[0] && !ctrl_q[1] |-> !NMI_MASK)
        else $error("nmi masked without cause");

    a_rd_undef: assert property (@(posedge CLK) disable iff (SYS_RST)
        MODE_FLAGS.rd_undef == (MODE_FLAGS.write_act || MODE_FLAGS.erase_act))
        else $error("read flag mismatch");

    a_boot_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
        boot_q && !boot_arm_q && !(FETCH_VALID && (FETCH_ADDR >= fpep_pkg::BOOT_RAM_LO) &&
        (FETCH_ADDR <= fpep_pkg::BOOT_RAM_HI)) |=> boot_q && NMI_MASK)
        else $error("boot phase left early");

    a_boot_exit: assert property (@(posedge CLK) disable iff (SYS_RST)
        !boot_arm_q && FETCH_VALID && (FETCH_ADDR >= fpep_pkg::BOOT_RAM_LO) &&
        (FETCH_ADDR <= fpep_pkg::BOOT_RAM_HI) |=> !boot_q)
        else $error("boot phase kept after branch");

    a_hwsb_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
        HW_STANDBY |=> !err_q && (ctrl_q == 7'h00) && (eblk_q == 8'h00))
        else $error("hardware standby did not clear");

    a_swsb_init: assert property (@(posedge CLK) disable iff (SYS_RST)
        SW_STANDBY && err_q && !err_clear |=> err_q && (ctrl_q == 7'h00) && (eblk_q == 8'h00))
        else $error("software standby did not initialise");

endmodule

`default_nettype wire

// ---- fpep_pkg.sv ----
// Shared constants and types for the flash program/erase protection block.
// Assumes a single 125 MHz clock and an APB register port with 32-bit data.
`default_nettype none

package fpep_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_EBLK   = 8'h04;
    localparam logic [7:0] OFF_STAT   = 8'h08;
    localparam logic [7:0] OFF_RAMCTL = 8'h0c;

    // Flash control register fields.
    localparam int CTRL_W       = 7;
    localparam int B_WRITE      = 0;
    localparam int B_ERASE      = 1;
    localparam int B_WCHECK     = 2;
    localparam int B_ECHECK     = 3;
    localparam int B_WSETUP     = 4;
    localparam int B_ESETUP     = 5;
    localparam int B_SWGATE     = 6;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

    // Erase block select register.
    localparam int EBLK_W = 8;
    localparam logic [EBLK_W-1:0] EBLK_RST = 8'h00;

    // Status register fields.
    localparam int S_MODE_LO = 0;
    localparam int S_NMI     = 3;
    localparam int S_FWE     = 4;
    localparam int S_BOOT    = 5;
    localparam int S_ERR     = 7;

    // RAM overlay control: select bit and area field.
    localparam int RAMCTL_W  = 4;
    localparam int R_SELECT  = 3;
    localparam logic [RAMCTL_W-1:0] RAMCTL_RST = 4'h0;

    // On-chip RAM boot program area.
    localparam logic [19:0] BOOT_RAM_LO = 20'hfef10;
    localparam logic [19:0] BOOT_RAM_HI = 20'hff2ff;

    typedef enum logic [2:0] {
        MODE_IDLE   = 3'b000,
        MODE_WSETUP = 3'b001,
        MODE_WRITE  = 3'b010,
        MODE_ESETUP = 3'b011,
        MODE_ERASE  = 3'b100,
        MODE_WCHECK = 3'b101,
        MODE_ECHECK = 3'b110
    } fpep_mode_t;

    typedef struct packed {
        logic write_act;
        logic erase_act;
        logic wcheck_act;
        logic echeck_act;
        logic rd_undef;
    } fpep_out_t;

endpackage

`default_nettype wire

// ---- fpep_cpu.sv ----
// CPU-side model: the programming software acting as register port master.
// Assumes an APB slave on CLK that answers with a PREADY pulse per access.
`timescale 1ns/1ns
`default_nettype none

module fpep_cpu (
    input  wire logic        CLK,
    output var  logic        PSEL,
    output var  logic        PENABLE,
    output var  logic        PWRITE,
    output var  logic [7:0]  PADDR,
    output var  logic [31:0] PWDATA,
    input  wire logic [31:0] PRDATA,
    input  wire logic        PREADY,
    input  wire logic        PSLVERR
);
    initial begin
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0000_0000;
    end

    // One transfer; starts a clock later so no signal is assigned twice per step.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic ok);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        ok = (PREADY === 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        // Released lines show the inverse, so stale values cannot pass by luck.
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        PADDR <= ~a;
        PWDATA <= ~d;
    endtask
endmodule

`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the flash program/erase protection block.
// Assumes fpep_pkg and the fpep_cpu register port master are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    logic                clk = 1'b0;
    logic                sys_rst = 1'b1;
    logic                psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, v;
    // No interrupt or bus release is ever requested while the pin is high.
    logic                fwe_pin = 1'b1;
    logic                boot_pin = 1'b0;
    logic                fetch_valid = 1'b0;
    logic [19:0]         fetch_addr = 20'h00000;
    logic                wdt_rst = 1'b0;
    logic                hw_sb = 1'b0;
    logic                sw_sb = 1'b0;
    logic                runaway = 1'b0;
    fpep_pkg::fpep_out_t mode;
    logic [7:0]          blk_en;
    logic [2:0]          ovl_area;
    logic                ovl_en, nmi;
    int                  n_fail = 0;
    int                  compares = 0;

    always #4 clk = ~clk;

    fpep_cpu u_fpep_cpu (.CLK(clk), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr));

    fpep_prot u_fpep_prot (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .FLASH_WRITE_ENABLE_PIN(fwe_pin), .BOOT_MODE_PIN(boot_pin),
        .WATCHDOG_UNIT_RST(wdt_rst), .HW_STANDBY(hw_sb), .SW_STANDBY(sw_sb),
        .CPU_RUNAWAY(runaway), .FETCH_VALID(fetch_valid), .FETCH_ADDR(fetch_addr),
        .MODE_FLAGS(mode), .ERASE_BLOCK_EN(blk_en), .OVERLAY_AREA(ovl_area),
        .OVERLAY_EN(ovl_en), .NMI_MASK(nmi));

    task automatic wrap_up();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic io(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ok;
        u_fpep_cpu.xfer(w, a, d, v, e, ok);
        if (ok !== 1'b1) begin
            n_fail++;
            $display("MISMATCH pready expected 1 seen timeout");
            wrap_up();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        io(1'b1, a, d);
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        io(1'b0, a, 32'h0);
        chk(what, exp, v);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic t_reset();
        rchk("ctrl", fpep_pkg::OFF_CTRL, 32'h0);
        rchk("eblk", fpep_pkg::OFF_EBLK, 32'h0);
        rchk("ramctl", fpep_pkg::OFF_RAMCTL, 32'h0);
        chk("nmi", 32'h0, 32'(nmi));
        io(1'b0, 8'h10, 32'h0);
        chk("slverr", 32'h1, 32'(e));
        chk("rdata", 32'h0, v);
    endtask

    task automatic t_prog();
        wr(fpep_pkg::OFF_CTRL, 32'h50);
        wr(fpep_pkg::OFF_CTRL, 32'h51);
        tick(2);
        chk("write_act", 32'h1, 32'(mode.write_act));
        chk("rd_undef", 32'h1, 32'(mode.rd_undef));
        chk("nmi", 32'h1, 32'(nmi));
        wr(fpep_pkg::OFF_CTRL, 32'h50);
        wr(fpep_pkg::OFF_CTRL, 32'h11);
        tick(2);
        chk("write_act", 32'h0, 32'(mode.write_act));
        chk("nmi", 32'h1, 32'(nmi));
        wr(fpep_pkg::OFF_CTRL, 32'h0);
        tick(2);
        chk("nmi", 32'h0, 32'(nmi));
    endtask

    task automatic t_erase();
        wr(fpep_pkg::OFF_CTRL, 32'h60);
        wr(fpep_pkg::OFF_CTRL, 32'h62);
        tick(2);
        chk("erase_act", 32'h0, 32'(mode.erase_act));
        wr(fpep_pkg::OFF_CTRL, 32'h60);
        wr(fpep_pkg::OFF_EBLK, 32'h05);
        wr(fpep_pkg::OFF_CTRL, 32'h62);
        tick(2);
        chk("erase_act", 32'h1, 32'(mode.erase_act));
        chk("blk_en", 32'h05, 32'(blk_en));
        // The pin passes a two-stage synchroniser, so allow it a few cycles.
        fwe_pin <= 1'b0;
        tick(4);
        chk("erase_act", 32'h0, 32'(mode.erase_act));
        chk("blk_en", 32'h0, 32'(blk_en));
        rchk("ctrl", fpep_pkg::OFF_CTRL, 32'h0);
        rchk("eblk", fpep_pkg::OFF_EBLK, 32'h0);
        fwe_pin <= 1'b1;
        tick(4);
        wr(fpep_pkg::OFF_EBLK, 32'h0);
    endtask

    task automatic t_ovl();
        wr(fpep_pkg::OFF_RAMCTL, 32'he);
        wr(fpep_pkg::OFF_CTRL, 32'h50);
        wr(fpep_pkg::OFF_CTRL, 32'h51);
        tick(2);
        chk("ovl_en", 32'h1, 32'(ovl_en));
        chk("ovl_area", 32'h6, 32'(ovl_area));
        chk("write_act", 32'h0, 32'(mode.write_act));
        wr(fpep_pkg::OFF_CTRL, 32'h44);
        tick(2);
        chk("wcheck_act", 32'h1, 32'(mode.wcheck_act));
        fwe_pin <= 1'b0;
        tick(4);
        chk("ovl_en", 32'h0, 32'(ovl_en));
        chk("wcheck_act", 32'h0, 32'(mode.wcheck_act));
        fwe_pin <= 1'b1;
        tick(4);
    endtask

    task automatic t_err();
        wr(fpep_pkg::OFF_CTRL, 32'h40);
        runaway <= 1'b1;
        tick(1);
        runaway <= 1'b0;
        rchk("err", fpep_pkg::OFF_STAT, 32'h10);
        wr(fpep_pkg::OFF_CTRL, 32'h41);
        io(1'b0, fpep_pkg::OFF_STAT, 32'h0);
        chk("err", 32'h1, 32'(v[7]));
        rchk("ctrl", fpep_pkg::OFF_CTRL, 32'h41);
        chk("nmi", 32'h1, 32'(nmi));
        wr(fpep_pkg::OFF_CTRL, 32'h50);
        wr(fpep_pkg::OFF_CTRL, 32'h51);
        tick(2);
        chk("write_act", 32'h0, 32'(mode.write_act));
        wr(fpep_pkg::OFF_CTRL, 32'h48);
        tick(2);
        chk("echeck_act", 32'h1, 32'(mode.echeck_act));
        wr(fpep_pkg::OFF_STAT, 32'h0);
        sw_sb <= 1'b1;
        tick(1);
        sw_sb <= 1'b0;
        tick(2);
        rchk("ctrl", fpep_pkg::OFF_CTRL, 32'h0);
        io(1'b0, fpep_pkg::OFF_STAT, 32'h0);
        chk("err", 32'h1, 32'(v[7]));
        wdt_rst <= 1'b1;
        tick(1);
        wdt_rst <= 1'b0;
        tick(2);
        io(1'b0, fpep_pkg::OFF_STAT, 32'h0);
        chk("err", 32'h0, 32'(v[7]));
    endtask

    task automatic t_run();
        wr(fpep_pkg::OFF_CTRL, 32'h50);
        wr(fpep_pkg::OFF_CTRL, 32'h51);
        runaway <= 1'b1;
        tick(1);
        runaway <= 1'b0;
        tick(2);
        chk("write_act", 32'h0, 32'(mode.write_act));
        rchk("ctrl", fpep_pkg::OFF_CTRL, 32'h51);
        sys_rst <= 1'b1;
        tick(20);
        sys_rst <= 1'b0;
        tick(4);
        rchk("stat", fpep_pkg::OFF_STAT, 32'h10);
        wr(fpep_pkg::OFF_CTRL, 32'h40);
        hw_sb <= 1'b1;
        tick(1);
        hw_sb <= 1'b0;
        tick(2);
        rchk("ctrl", fpep_pkg::OFF_CTRL, 32'h0);
    endtask

    task automatic fetch(input logic [19:0] a);
        fetch_addr  <= a;
        fetch_valid <= 1'b1;
        tick(1);
        fetch_valid <= 1'b0;
        tick(2);
    endtask

    task automatic t_boot();
        boot_pin <= 1'b1;
        sys_rst  <= 1'b1;
        tick(20);
        sys_rst  <= 1'b0;
        tick(4);
        rchk("stat", fpep_pkg::OFF_STAT, 32'h38);
        fetch(20'hfef0f);
        fetch(20'hff300);
        chk("nmi", 32'h1, 32'(nmi));
        fetch(fpep_pkg::BOOT_RAM_LO);
        chk("nmi", 32'h0, 32'(nmi));
        boot_pin <= 1'b0;
    endtask

    initial begin
        // Oscillator settling is not modelled; this reset stands for its end.
        tick(10);
        sys_rst <= 1'b0;
        tick(4);
        t_reset();
        t_prog();
        t_erase();
        t_ovl();
        t_err();
        t_run();
        t_boot();
        wrap_up();
    end
endmodule

`default_nettype wire
